// ---- verilog/spi_port_cfg.svh ----
// constants and register map of the spi master/slave port
// Operation
// - modes 0000/0001/0010 are master, sck at clock divided by 4, 16, 64.
// - mode 0011 is master, sck is timer-two tick rate divided by two.
// - mode 0100 is slave with slave-select; 0101 slave ignoring slave-select.
// - each transfer moves eight bits out and eight in together.
// - data leaves and enters most significant bit first.
// - after eight bits, copy byte to buffer, set full and interrupt flags.
// - receive is double buffered; next byte may arrive before buffer read.
// - buffer write during transfer is dropped and sets write collision flag.
// - reading the data buffer clears the buffer full flag.
// - shift register reached only through the data buffer.
// - enable bit hands pins to the port; reconfigure with enable cleared.
// - in master mode a buffer write starts an eight-bit transfer at once.
// - master keeps shifting sdi in even with sdo output disabled.
// - clock polarity bit chooses the idle sck level.
// - with edge select set, first sdo bit is valid before first sck edge.
// - slave shifts on external sck and flags when eighth bit latched.
// - slave logic runs during sleep; a finished byte wakes the device.
// - polarity one idles sck high, zero idles it low.
// - edge select picks which sck edge changes sdo, swapped by polarity.
// - sample bit set samples at end of output time, clear at middle; slave ignores it and always samples at middle.
// - slave-select high floats sdo at once and resets the bit counter.
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH
`define SPI_ADR_BUF 8'h00
`define SPI_ADR_STAT 8'h04
`define SPI_ADR_CTL 8'h08
`define SPI_ADR_FLAG 8'h0c
`define SPI_STAT_PHASE 7
`define SPI_STAT_EDGE 6
`define SPI_STAT_FULL 0
`define SPI_CTL_COL 7
`define SPI_CTL_OVF 6
`define SPI_CTL_EN 5
`define SPI_CTL_POL 4
`define SPI_FLAG_IRQ 3
`define SPI_MODE_DIV4 4'h0
`define SPI_MODE_DIV16 4'h1
`define SPI_MODE_DIV64 4'h2
`define SPI_MODE_TMR 4'h3
`define SPI_MODE_SSEL 4'h4
`define SPI_MODE_FREE 4'h5
`define SPI_HALF_DIV4 6'h01
`define SPI_HALF_DIV16 6'h07
`define SPI_HALF_DIV64 6'h1f
`define SPI_HALF_LAST 5'h0f
`define SPI_HALF_END 5'h10
`define SPI_BIT_LAST 3'h7
`endif

// ---- verilog/spi_port_pkg.sv ----
// types shared by the spi master/slave port
package spi_port_pkg;
   typedef enum logic {m_idle, m_run} master_state_t;
endpackage

// ---- verilog/spi_master_slave_port.sv ----
// spi master/slave port with classic wishbone register slave
`timescale 1ns/1ps
`include "spi_port_cfg.svh"
module spi_master_slave_port (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // serial pins
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_o,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   input wire logic slave_sel_n_i,
   // system
   input wire logic timer_two_tick_i,
   output logic wake_o
);
   spi_port_pkg::master_state_t state_ff, nxt_state;
   logic ack_ff, pol_ff, en_ff, phase_ff, edge_ff, full_ff, irq_ff, col_ff, ovf_ff;
   logic [3:0] mode_ff;
   logic [7:0] buf_ff, tx_ff, rx_ff;
   logic [31:0] dat_ff;
   logic [5:0] div_ff;
   logic [4:0] half_ff;
   logic [2:0] bit_ff;
   logic [1:0] msamp_dly_ff, mdone_dly_ff;
   logic sck_ff, sdo_ff, sck_oe_ff, sdo_oe_ff, wake_ff;
   logic sck_m_ff, sck_s_ff, sck_d_ff, sdi_m_ff, sdi_s_ff, sel_m_ff, sel_s_ff;

   // register bus decode
   wire req = wb_cyc_i && wb_stb_i && !ack_ff;
   wire wr = req && wb_we_i && wb_sel_i[0];
   wire rd = req && !wb_we_i;
   wire wr_buf = wr && wb_adr_i == `SPI_ADR_BUF;
   wire wr_stat = wr && wb_adr_i == `SPI_ADR_STAT;
   wire wr_ctl = wr && wb_adr_i == `SPI_ADR_CTL;
   wire wr_flag = wr && wb_adr_i == `SPI_ADR_FLAG;
   wire rd_buf = rd && wb_adr_i == `SPI_ADR_BUF;
   wire [7:0] wd = wb_dat_i[7:0];

   // mode decode
   wire is_master = en_ff && mode_ff <= `SPI_MODE_TMR;
   wire is_slave = en_ff && (mode_ff == `SPI_MODE_SSEL || mode_ff == `SPI_MODE_FREE);
   wire sel_used = mode_ff == `SPI_MODE_SSEL;
   wire slave_act = is_slave && !(sel_used && sel_s_ff);
   wire running = state_ff == spi_port_pkg::m_run;
   wire busy = running || mdone_dly_ff != 2'b00 || (is_slave && bit_ff != 3'h0);

   // master half-period ticks
   wire [5:0] half_div = (mode_ff == `SPI_MODE_DIV4) ? `SPI_HALF_DIV4 :
      (mode_ff == `SPI_MODE_DIV16) ? `SPI_HALF_DIV16 : `SPI_HALF_DIV64;
   wire tick = running && ((mode_ff == `SPI_MODE_TMR) ? timer_two_tick_i :
      div_ff == half_div);
   wire h_lead = !half_ff[0] && half_ff != `SPI_HALF_END;
   wire h_trail = half_ff[0];
   wire m_done = tick && half_ff == `SPI_HALF_END;
   wire m_out = tick && (edge_ff ? (h_trail && half_ff != `SPI_HALF_LAST) : h_lead);
   wire m_mid = edge_ff ? h_lead : h_trail;
   wire m_end = edge_ff ? h_trail : (!half_ff[0] && half_ff != 5'h00);
   wire m_samp = tick && (phase_ff ? m_end : m_mid);

   // slave edges from synchronised sck
   wire s_edge = slave_act && (sck_s_ff != sck_d_ff);
   wire s_lead = s_edge && (sck_s_ff != pol_ff);
   wire s_trail = s_edge && (sck_s_ff == pol_ff);
   wire s_out = edge_ff ? s_trail : s_lead;
   wire s_samp = edge_ff ? s_lead : s_trail;
   wire s_done = s_samp && bit_ff == `SPI_BIT_LAST;

   wire out_ev = m_out || s_out;
   wire samp_ev = msamp_dly_ff[1] || s_samp;
   wire [7:0] rx_nxt = samp_ev ? {rx_ff[6:0], sdi_s_ff} : rx_ff;
   wire done = mdone_dly_ff[1] || s_done;
   // a slave byte arriving on a full buffer is lost; a master never overflows
   wire lost = s_done && full_ff;
   wire take = done && !lost;
   wire load = wr_buf && !busy && (is_master || is_slave);
   wire start = load && is_master;

   // read mux
   wire [7:0] rd_byte =
      (wb_adr_i == `SPI_ADR_BUF) ? buf_ff :
      (wb_adr_i == `SPI_ADR_STAT) ? {phase_ff, edge_ff, 5'h00, full_ff} :
      (wb_adr_i == `SPI_ADR_CTL) ? {col_ff, ovf_ff, en_ff, pol_ff, mode_ff} :
      (wb_adr_i == `SPI_ADR_FLAG) ? {4'h0, irq_ff, 3'h0} : 8'h00;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         spi_port_pkg::m_idle: begin
            if (start) begin
               nxt_state = spi_port_pkg::m_run;
            end
         end
         spi_port_pkg::m_run: begin
            if (m_done || !is_master) begin
               nxt_state = spi_port_pkg::m_idle;
            end
         end
      endcase
   end

   // pin synchronisers
   always_ff @(posedge clk_i) begin
      sck_m_ff <= sck_i;
      sck_s_ff <= sck_m_ff;
      sck_d_ff <= sck_s_ff;
      sdi_m_ff <= sdi_i;
      sdi_s_ff <= sdi_m_ff;
      sel_m_ff <= slave_sel_n_i;
      sel_s_ff <= sel_m_ff;
   end

   // wishbone answer, one wait state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0;
      end else begin
         ack_ff <= req;
         dat_ff <= req ? {24'h0, rd_byte} : 32'h0;
      end
   end

   // configuration
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_ff <= 1'b0;
         pol_ff <= 1'b0;
         mode_ff <= 4'h0;
         phase_ff <= 1'b0;
         edge_ff <= 1'b0;
      end else begin
         if (wr_ctl) begin
            en_ff <= wd[`SPI_CTL_EN];
            pol_ff <= wd[`SPI_CTL_POL];
            mode_ff <= wd[3:0];
         end
         if (wr_stat) begin
            phase_ff <= wd[`SPI_STAT_PHASE];
            edge_ff <= wd[`SPI_STAT_EDGE];
         end
      end
   end

   // status flags: hardware set beats software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         col_ff <= 1'b0;
         ovf_ff <= 1'b0;
         full_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         col_ff <= (wr_buf && busy) || (wr_ctl ? wd[`SPI_CTL_COL] : col_ff);
         ovf_ff <= lost || (wr_ctl ? wd[`SPI_CTL_OVF] : ovf_ff);
         full_ff <= take || (full_ff && !rd_buf);
         irq_ff <= done || (wr_flag ? wd[`SPI_FLAG_IRQ] : irq_ff);
      end
   end

   // data buffer, only path to the shift registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         buf_ff <= 8'h00;
      end else if (take) begin
         buf_ff <= rx_nxt;
      end else if (load) begin
         buf_ff <= wd;
      end
   end

   // master sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= spi_port_pkg::m_idle;
         div_ff <= 6'h00;
         half_ff <= 5'h00;
      end else begin
         state_ff <= nxt_state;
         if (!running || tick) begin
            div_ff <= 6'h00;
         end else begin
            div_ff <= div_ff + 6'h01;
         end
         if (!running) begin
            half_ff <= 5'h00;
         end else if (tick) begin
            half_ff <= half_ff + 5'h01;
         end
      end
   end

   // master samples wait out the sdi synchroniser lag, so the bit
   // that stood on the line as sck moved is taken, even at divide by 4
   always_ff @(posedge clk_i) begin
      if (rst_i || !is_master) begin
         msamp_dly_ff <= 2'b00;
         mdone_dly_ff <= 2'b00;
      end else begin
         msamp_dly_ff <= {msamp_dly_ff[0], m_samp};
         mdone_dly_ff <= {mdone_dly_ff[0], m_done};
      end
   end

   // shift path
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_ff <= 8'h00;
         rx_ff <= 8'h00;
         sdo_ff <= 1'b0;
         bit_ff <= 3'h0;
      end else begin
         if (load) begin
            tx_ff <= edge_ff ? {wd[6:0], 1'b0} : wd;
            if (edge_ff) begin
               sdo_ff <= wd[7];
            end
         end else if (out_ev) begin
            sdo_ff <= tx_ff[7];
            tx_ff <= {tx_ff[6:0], 1'b0};
         end
         rx_ff <= rx_nxt;
         if (!en_ff || (is_slave && !slave_act) || start) begin
            bit_ff <= 3'h0;
         end else if (samp_ev) begin
            bit_ff <= bit_ff + 3'h1;
         end
      end
   end

   // pin drivers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_ff <= 1'b0;
         sck_oe_ff <= 1'b0;
         sdo_oe_ff <= 1'b0;
         wake_ff <= 1'b0;
      end else begin
         if (!running) begin
            sck_ff <= pol_ff;
         end else if (tick && half_ff != `SPI_HALF_END) begin
            sck_ff <= !sck_ff;
         end
         sck_oe_ff <= is_master;
         sdo_oe_ff <= is_master || slave_act;
         // slave path needs no master clock, so a byte can end a sleep
         wake_ff <= s_done;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign sck_o = sck_ff;
   assign sck_oe_o = sck_oe_ff;
   assign sdo_o = sdo_ff;
   assign sdo_oe_o = sdo_oe_ff;
   assign wake_o = wake_ff;

   property p_div4;
      @(posedge clk_i) disable iff (rst_i)
      (tick && mode_ff == `SPI_MODE_DIV4 && half_ff < `SPI_HALF_LAST) |=> !tick ##1 tick;
   endproperty
   a_div4: assert property (p_div4) else $error("div4 half period wrong");
   property p_timer;
      @(posedge clk_i) disable iff (rst_i)
      (running && mode_ff == `SPI_MODE_TMR && !timer_two_tick_i) |=> $stable(sck_ff);
   endproperty
   a_timer: assert property (p_timer) else $error("sck moved without timer tick");
   property p_take;
      @(posedge clk_i) disable iff (rst_i)
      take |=> full_ff && irq_ff && buf_ff == $past(rx_nxt);
   endproperty
   a_take: assert property (p_take) else $error("byte not posted");
   property p_collide;
      @(posedge clk_i) disable iff (rst_i)
      (wr_buf && busy) |=> col_ff && $stable(tx_ff) || $past(out_ev);
   endproperty
   a_collide: assert property (p_collide) else $error("collision missed");
   property p_rdclr;
      @(posedge clk_i) disable iff (rst_i)
      (rd_buf && !take) |=> !full_ff;
   endproperty
   a_rdclr: assert property (p_rdclr) else $error("full not cleared");
   property p_start;
      @(posedge clk_i) disable iff (rst_i)
      start |=> running ##0 half_ff == 5'h00;
   endproperty
   a_start: assert property (p_start) else $error("master did not start");
   property p_msb;
      @(posedge clk_i) disable iff (rst_i)
      (out_ev && !load) |=> sdo_ff == $past(tx_ff[7]);
   endproperty
   a_msb: assert property (p_msb) else $error("bit order wrong");
   property p_float;
      @(posedge clk_i) disable iff (rst_i)
      (is_slave && sel_used && sel_s_ff) |=> !sdo_oe_ff && bit_ff == 3'h0;
   endproperty
   a_float: assert property (p_float) else $error("slave select ignored");
   property p_abort;
      @(posedge clk_i) disable iff (rst_i)
      !en_ff |=> !running && bit_ff == 3'h0 && !sck_oe_ff;
   endproperty
   a_abort: assert property (p_abort) else $error("disable did not abort");
   property p_badmode;
      @(posedge clk_i) disable iff (rst_i)
      (mode_ff > `SPI_MODE_FREE) |=> !sdo_oe_ff && !sck_oe_ff;
   endproperty
   a_badmode: assert property (p_badmode) else $error("spi active in other mode");
   property p_wake;
      @(posedge clk_i) disable iff (rst_i)
      s_done |=> wake_ff && irq_ff;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on slave byte");
   property p_idle;
      @(posedge clk_i) disable iff (rst_i)
      !running |=> sck_ff == $past(pol_ff);
   endproperty
   a_idle: assert property (p_idle) else $error("sck not at idle level");
   property p_first;
      @(posedge clk_i) disable iff (rst_i)
      (start && edge_ff) |=> sdo_ff == $past(wd[7]);
   endproperty
   a_first: assert property (p_first) else $error("first bit not preset");
   property p_colkeep;
      @(posedge clk_i) disable iff (rst_i)
      (col_ff && !wr_ctl) |=> col_ff;
   endproperty
   a_colkeep: assert property (p_colkeep) else $error("collision flag dropped");
   c_master: cover property (@(posedge clk_i) disable iff (rst_i) m_done);
   c_slave: cover property (@(posedge clk_i) disable iff (rst_i) s_done && !lost);
   c_collide: cover property (@(posedge clk_i) disable iff (rst_i) wr_buf && busy);
   c_lost: cover property (@(posedge clk_i) disable iff (rst_i) lost);
endmodule // spi_master_slave_port

// ---- sim/spi_peer_model.sv ----
// behavioural spi peripheral facing the port in master mode
`timescale 1ns/1ps
module spi_peer_model (
   // serial pins
   input wire logic sck_i,
   input wire logic sdo_i,
   output logic sdi_o,
   // set up by the bench
   input wire logic pol_i,
   input wire logic edge_i,
   input wire logic load_i,
   input wire logic [7:0] tx_i,
   output logic [7:0] rx_o
);
   logic [7:0] sh = 8'h00;
   logic seen = 1'b0;
   logic lead;
   always @(posedge load_i) begin
      sh = tx_i;
      seen = 1'b0;
   end
   // msb leaves first; inverted fill so a stale line never looks valid
   always @(sck_i) begin
      lead = (sck_i != pol_i);
      if (lead != edge_i) begin
         if (edge_i || seen) begin
            sh = {sh[6:0], ~sh[7]};
         end
         seen = 1'b1;
      end else begin
         rx_o = {rx_o[6:0], sdo_i};
      end
   end
   assign sdi_o = sh[7];
endmodule // spi_peer_model

// ---- sim/spi_master_slave_port_bench.sv ----
// self-checking bench of the spi master/slave port
`timescale 1ns/1ps
`include "spi_port_cfg.svh"
module spi_master_slave_port_bench;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, tick = 0;
   logic sck_d = 0, sdi_d = 0, sel_n = 1, ld = 0, pol = 0, edg = 0, slv = 0;
   logic [7:0] adr = 0, ptx = 0, got;
   logic [3:0] sel = 0;
   logic [31:0] dat = 0, rd, r;
   wire logic [31:0] rdat;
   wire logic ack, sck_o, sck_oe, sdo, sdo_oe, wake, psdi;
   wire logic [7:0] prx;
   int fails = 0, samples_checked = 0, cyc_n = 0, act = 0, edges = 0, wakes = 0;
   initial forever #2.5 clk_i = ~clk_i;
   spi_master_slave_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .sck_i(sck_d), .sck_o(sck_o), .sck_oe_o(sck_oe),
      .sdi_i(slv ? sdi_d : psdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .slave_sel_n_i(sel_n),
      .timer_two_tick_i(tick), .wake_o(wake));
   spi_peer_model i_peer (.sck_i(sck_o), .sdo_i(sdo), .sdi_o(psdi), .pol_i(pol),
      .edge_i(edg), .load_i(ld), .tx_i(ptx), .rx_o(prx));
   always @(posedge clk_i) begin
      cyc_n++;
      tick <= (cyc_n % 4 == 0);
      if (sck_oe === 1'b1 && sck_o !== pol) act++;
      if (wake === 1'b1) wakes++;
      if (cyc_n > 60000) begin
         fails++;
         wrap_up();
      end
   end
   always @(sck_o) edges++;
   task wrap_up;
      if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // holds the request until ack is sampled high
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'h1;
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 0; stb <= 0;
   endtask
   task cfg(input logic [3:0] m, input logic p, input logic e, input logic s);
      pol = p;
      edg = e;
      wb(1, `SPI_ADR_CTL, {27'h0, p, m});
      wb(1, `SPI_ADR_STAT, {24'h0, s, e, 6'h0});
      wb(1, `SPI_ADR_CTL, {26'h0, 1'b1, p, m});
   endtask
   function int half(input logic [3:0] m);
      return m == 0 ? 2 : m == 1 ? 8 : m == 2 ? 32 : 4;
   endfunction
   task master(input logic [3:0] m);
      int k;
      r = $urandom;
      ptx = r[15:8];
      cfg(m, r[0], r[1], r[2]);
      repeat (2) @(posedge clk_i);
      chk(32'(sck_o), 32'(pol));
      chk(32'(sck_oe), 1);
      chk(32'(sdo_oe), 1);
      ld <= 1;
      @(posedge clk_i);
      ld <= 0;
      act = 0;
      edges = 0;
      wb(1, `SPI_ADR_BUF, {24'h0, r[23:16]});
      wb(1, `SPI_ADR_BUF, {24'h0, ~r[23:16]});
      wb(0, `SPI_ADR_CTL, 0);
      chk(32'(rd[7]), 1);
      k = 0;
      do begin
         wb(0, `SPI_ADR_STAT, 0);
         k++;
      end while (rd[0] !== 1'b1 && k < 200);
      chk(32'(edges), 16);
      chk(32'(act), 32'(8 * half(m)));
      chk(32'(prx), 32'(r[23:16]));
      wb(0, `SPI_ADR_FLAG, 0);
      chk(32'(rd[3]), 1);
      wb(0, `SPI_ADR_BUF, 0);
      chk(rd, 32'(ptx));
      wb(0, `SPI_ADR_STAT, 0);
      chk(32'(rd[0]), 0);
      wb(1, `SPI_ADR_CTL, {26'h0, 1'b1, pol, m});
      wb(0, `SPI_ADR_CTL, 0);
      chk(32'(rd[7]), 0);
      wb(1, `SPI_ADR_FLAG, 0);
   endtask
   // bench acts as external master: ten clocks a half period
   task slave_bits(input int n, input logic [7:0] b);
      for (int i = 7; i > 7 - n; i--) begin
         repeat (5) @(posedge clk_i);
         sdi_d <= b[i];
         repeat (5) @(posedge clk_i);
         sck_d <= 1;
         repeat (8) @(posedge clk_i);
         got[i] = sdo;
         repeat (2) @(posedge clk_i);
         sck_d <= 0;
      end
   endtask
   task slave(input logic [3:0] m);
      r = $urandom;
      slv <= 1;
      sel_n <= (m == `SPI_MODE_FREE);
      cfg(m, 0, 0, 0);
      wakes = 0;
      if (m == `SPI_MODE_SSEL) begin
         slave_bits(3, ~r[15:8]);
         sel_n <= 1;
         repeat (4) @(posedge clk_i);
         chk(32'(sdo_oe), 0);
         sel_n <= 0;
         repeat (4) @(posedge clk_i);
      end
      wb(1, `SPI_ADR_BUF, {24'h0, r[7:0]});
      chk(32'(sck_oe), 0);
      chk(32'(sdo_oe), 1);
      slave_bits(8, r[15:8]);
      repeat (10) @(posedge clk_i);
      chk(32'(wakes), 1);
      chk(32'(got), 32'(r[7:0]));
      wb(0, `SPI_ADR_FLAG, 0);
      chk(32'(rd[3]), 1);
      wb(0, `SPI_ADR_BUF, 0);
      chk(rd, 32'(r[15:8]));
      wb(1, `SPI_ADR_FLAG, 0);
   endtask
   initial begin
      r = $urandom(32);
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      wb(1, 8'h10, 32'h0000_00ff);
      for (int a = 0; a <= 16; a += 4) begin
         wb(0, 8'(a), 0);
         chk(rd, 0);
      end
      for (int m = 0; m < 4; m++) begin
         repeat (2) master(4'(m));
      end
      // disable mid-byte, then a full byte must still be eight bits
      cfg(`SPI_MODE_DIV64, 0, 1, 0);
      wb(1, `SPI_ADR_BUF, 32'h5a);
      repeat (100) @(posedge clk_i);
      wb(1, `SPI_ADR_CTL, 32'h02);
      repeat (4) @(posedge clk_i);
      chk(32'(sck_oe), 0);
      wb(0, `SPI_ADR_STAT, 0);
      chk(32'(rd[0]), 0);
      master(`SPI_MODE_DIV64);
      cfg(4'h6, 0, 1, 0);
      edges = 0;
      wb(1, `SPI_ADR_BUF, 32'h3c);
      repeat (100) @(posedge clk_i);
      chk(32'(edges), 0);
      wb(0, `SPI_ADR_STAT, 0);
      chk(32'(rd[0]), 0);
      slave(`SPI_MODE_SSEL);
      slave(`SPI_MODE_FREE);
      wrap_up();
   end
endmodule // spi_master_slave_port_bench
